// File: core/abw_pkg.sv
// Package for the per-area bus width and access state configuration block
package abw_pkg;
  // Register byte offsets on the register bus
  localparam logic [7:0] ADDR_WIDTH_SEL = 8'h00;
  localparam logic [7:0] ADDR_STATE_SEL = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  // Reset values
  localparam logic [7:0] WIDTH_RESET_MODE13 = 8'hff;
  localparam logic [7:0] WIDTH_RESET_MODE24 = 8'h00;
  localparam logic [7:0] STATE_RESET = 8'hff;
  localparam logic [7:0] ALL_EIGHT_BIT = 8'hff;
  // Control register field positions
  localparam int CTRL_ADDR24_BIT = 0;
  // Status register field positions
  localparam int STAT_BUS8_BIT = 0;
  localparam int STAT_MODE_LSB = 1;
  localparam int STAT_HWSTBY_BIT = 3;
  // Address mode area sizes as address bit of area index
  localparam int AREA_LSB_1MB = 17;
  localparam int AREA_LSB_16MB = 21;
  // Access states: fixed on-chip value and the two external choices
  localparam logic [1:0] ONCHIP_STATES = 2'h2;
  localparam logic [1:0] TWO_STATES = 2'h2;
  localparam logic [1:0] THREE_STATES = 2'h3;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: core/abw_area_select.sv
// Area decoder: picks width and state bits for the current bus cycle
`timescale 1ns/1ns
`default_nettype none
module abw_area_select #(
  parameter int ADDR_W = 24
) (
  // Access request
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_external,
  input wire logic i_addr24,
  // Configuration
  input wire logic [7:0] i_width_bits,
  input wire logic [7:0] i_state_bits,
  // Decoded attributes
  output logic [2:0] o_area,
  output logic o_eight_bit,
  output logic [1:0] o_states,
  output logic o_wait_honoured
);
  initial
  begin
    if (ADDR_W < abw_pkg::AREA_LSB_16MB + 3)
    begin
      $error("abw_area_select: address too narrow");
    end
  end

  // Area index from upper address bits, size set by the address mode
  always_comb
  begin
    if (i_addr24)
    begin
      o_area = i_addr[abw_pkg::AREA_LSB_16MB +: 3];
    end
    else
    begin
      o_area = i_addr[abw_pkg::AREA_LSB_1MB +: 3];
    end
  end

  // On-chip targets ignore both registers and use fixed width and states
  always_comb
  begin
    if (i_external)
    begin
      o_eight_bit = i_width_bits[o_area];
      o_states = i_state_bits[o_area] ? abw_pkg::THREE_STATES : abw_pkg::TWO_STATES;
    end
    else
    begin
      o_eight_bit = 1'b0;
      o_states = abw_pkg::ONCHIP_STATES;
    end
    o_wait_honoured = i_external && i_state_bits[o_area];
  end
endmodule
`default_nettype wire

// File: core/abw_config_regs.sv
// Per-area bus width and access state registers with AXI4-Lite slave
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module abw_config_regs #(
  parameter int ADDR_W = 24
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RESETN,
  // Operating mode and standby
  input wire logic [1:0] I_MODE,
  input wire logic I_HW_STANDBY,
  input wire logic I_SW_STANDBY,
  // AXI4-Lite write address and data
  input wire logic [7:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  // AXI4-Lite write response
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  // AXI4-Lite read
  input wire logic [7:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  // Current bus cycle
  input wire logic [ADDR_W-1:0] I_ACC_ADDR,
  input wire logic I_ACC_EXTERNAL,
  input wire logic I_WAIT_REQ,
  // Decoded bus cycle attributes
  output logic [2:0] O_AREA,
  output logic O_EIGHT_BIT,
  output logic [1:0] O_STATES,
  output logic O_WAIT_STRETCH,
  // Data bus and port configuration
  output logic O_BUS8_MODE,
  output logic O_LOW_BYTE_EN,
  output logic O_PORT4_GPIO,
  output logic [7:0] O_WIDTH_BITS,
  output logic [7:0] O_STATE_BITS
);
  initial
  begin
    if (ADDR_W < abw_pkg::AREA_LSB_16MB + 3)
    begin
      $error("abw_config_regs: address too narrow");
    end
  end

  // All state of the block
  typedef struct packed {
    logic [7:0] area_width_bits;
    logic [7:0] area_state_bits;
    logic addr24;
    logic hw_standby_seen;
    logic init_done;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic bus8;
  } abw_state_t;

  abw_state_t cur;
  abw_state_t next_cur;

  logic [2:0] area;
  logic eight_bit;
  logic [1:0] states;
  logic wait_ok;

  // Mode-dependent default of the width register
  function automatic logic [7:0] width_default(input logic [1:0] mode);
    // Modes 1 and 3 map to codes 1 and 3 (odd), modes 2 and 4 to 2 and 0
    if (mode[0])
    begin
      return abw_pkg::WIDTH_RESET_MODE13;
    end
    return abw_pkg::WIDTH_RESET_MODE24;
  endfunction

  // Byte-lane merge used for every writable register
  function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d,
                                       input logic [3:0] s);
    return s[0] ? d[7:0] : old;
  endfunction

  abw_area_select #(
    .ADDR_W(ADDR_W)
  ) u_sel (
    .i_addr(I_ACC_ADDR),
    .i_external(I_ACC_EXTERNAL),
    .i_addr24(cur.addr24),
    .i_width_bits(cur.area_width_bits),
    .i_state_bits(cur.area_state_bits),
    .o_area(area),
    .o_eight_bit(eight_bit),
    .o_states(states),
    .o_wait_honoured(wait_ok)
  );

  // Next-state logic: register init, bus slave and bus mode
  always_comb
  begin
    logic do_write;
    logic [31:0] rd;
    do_write = 1'b0;
    rd = 32'h0;
    next_cur = cur;
    // Mode strap is read once after reset release, since async reset loads constants only
    if (!cur.init_done)
    begin
      next_cur.init_done = 1'b1;
      next_cur.area_width_bits = width_default(I_MODE);
      // 16-Mbyte address modes are codes 3 and 0; codes 1 and 2 are 1-Mbyte modes
      next_cur.addr24 = ~(I_MODE[1] ^ I_MODE[0]);
    end
    // Write address and data taken in either order
    if (I_AWVALID && O_AWREADY)
    begin
      next_cur.aw_held = 1'b1;
      next_cur.aw_addr = I_AWADDR;
    end
    if (I_WVALID && O_WREADY)
    begin
      next_cur.w_held = 1'b1;
      next_cur.w_data = I_WDATA;
      next_cur.w_strb = I_WSTRB;
    end
    if (cur.aw_held && cur.w_held && !cur.bvalid)
    begin
      do_write = 1'b1;
      next_cur.aw_held = 1'b0;
      next_cur.w_held = 1'b0;
      next_cur.bvalid = 1'b1;
      next_cur.bresp = abw_pkg::RESP_OKAY;
      unique case (cur.aw_addr)
        abw_pkg::ADDR_WIDTH_SEL:
        begin
          next_cur.area_width_bits = lane0(cur.area_width_bits, cur.w_data, cur.w_strb);
        end
        abw_pkg::ADDR_STATE_SEL:
        begin
          next_cur.area_state_bits = lane0(cur.area_state_bits, cur.w_data, cur.w_strb);
        end
        abw_pkg::ADDR_CTRL, abw_pkg::ADDR_STATUS:
        begin
          // Control is fixed by the strap and status is read-only; write ignored
        end
        default:
        begin
          next_cur.bresp = abw_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (cur.bvalid && I_BREADY)
    begin
      next_cur.bvalid = 1'b0;
    end
    // Read: one outstanding at a time
    if (I_ARVALID && O_ARREADY)
    begin
      next_cur.rvalid = 1'b1;
      next_cur.rresp = abw_pkg::RESP_OKAY;
      unique case (I_ARADDR)
        abw_pkg::ADDR_WIDTH_SEL:
        begin
          rd[7:0] = cur.area_width_bits;
        end
        abw_pkg::ADDR_STATE_SEL:
        begin
          rd[7:0] = cur.area_state_bits;
        end
        abw_pkg::ADDR_CTRL:
        begin
          rd[abw_pkg::CTRL_ADDR24_BIT] = cur.addr24;
        end
        abw_pkg::ADDR_STATUS:
        begin
          rd[abw_pkg::STAT_BUS8_BIT] = cur.bus8;
          rd[abw_pkg::STAT_MODE_LSB +: 2] = I_MODE;
          rd[abw_pkg::STAT_HWSTBY_BIT] = cur.hw_standby_seen;
        end
        default:
        begin
          next_cur.rresp = abw_pkg::RESP_SLVERR;
        end
      endcase
      next_cur.rdata = rd;
    end
    else if (cur.rvalid && I_RREADY)
    begin
      next_cur.rvalid = 1'b0;
    end
    // Hardware standby reinitialises both registers and overrides any write;
    // software standby below holds contents, except for a bus write completing that cycle
    if (I_HW_STANDBY)
    begin
      next_cur.area_width_bits = width_default(I_MODE);
      next_cur.area_state_bits = abw_pkg::STATE_RESET;
    end
    next_cur.hw_standby_seen = I_HW_STANDBY;
    if (I_SW_STANDBY && !I_HW_STANDBY && !do_write)
    begin
      next_cur.area_width_bits = cur.area_width_bits;
      next_cur.area_state_bits = cur.area_state_bits;
    end
    // Bus mode is registered from the next width value, so it changes on the same edge as the width register
    next_cur.bus8 = (next_cur.area_width_bits == abw_pkg::ALL_EIGHT_BIT);
  end

  // State register; reset loads constants, mode default applied after release
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      cur <= '0;
      cur.area_width_bits <= abw_pkg::WIDTH_RESET_MODE13;
      cur.area_state_bits <= abw_pkg::STATE_RESET;
      cur.addr24 <= 1'b0;
      cur.bus8 <= 1'b1;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // Handshake outputs
  assign O_AWREADY = !cur.aw_held && cur.init_done;
  assign O_WREADY = !cur.w_held && cur.init_done;
  assign O_ARREADY = !cur.rvalid && cur.init_done;
  assign O_BVALID = cur.bvalid;
  assign O_BRESP = cur.bresp;
  assign O_RVALID = cur.rvalid;
  assign O_RRESP = cur.rresp;
  assign O_RDATA = cur.rdata;

  // Bus cycle attributes, combinational from the current address
  assign O_AREA = area;
  assign O_EIGHT_BIT = eight_bit;
  assign O_STATES = states;
  assign O_WAIT_STRETCH = wait_ok && I_WAIT_REQ;

  // Data bus and port use from the registered bus mode
  assign O_BUS8_MODE = cur.bus8;
  assign O_LOW_BYTE_EN = !cur.bus8;
  assign O_PORT4_GPIO = cur.bus8;
  assign O_WIDTH_BITS = cur.area_width_bits;
  assign O_STATE_BITS = cur.area_state_bits;
endmodule
`default_nettype wire

// File: dv/abw_checker.sv
// Assertion checker for the area width and state configuration block
`timescale 1ns/1ns
`default_nettype none
module abw_checker #(
  parameter int ADDR_W = 24
) (
  // Clock, reset, mode and standby
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic [1:0] I_MODE,
  input wire logic I_HW_STANDBY,
  input wire logic I_SW_STANDBY,
  // Register bus
  input wire logic O_AWREADY,
  input wire logic O_WREADY,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [31:0] O_RDATA,
  // Bus cycle
  input wire logic [ADDR_W-1:0] I_ACC_ADDR,
  input wire logic I_ACC_EXTERNAL,
  input wire logic I_WAIT_REQ,
  input wire logic [2:0] O_AREA,
  input wire logic O_EIGHT_BIT,
  input wire logic [1:0] O_STATES,
  input wire logic O_WAIT_STRETCH,
  // Bus and port configuration
  input wire logic O_BUS8_MODE,
  input wire logic O_LOW_BYTE_EN,
  input wire logic O_PORT4_GPIO,
  input wire logic [7:0] O_WIDTH_BITS,
  input wire logic [7:0] O_STATE_BITS
);
  logic mb1;
  logic sel3;
  logic [7:0] wdef;
  // Mode defaults and the state bit of the addressed external area
  assign mb1 = (I_MODE == 2'h1) || (I_MODE == 2'h2);
  assign wdef = (I_MODE == 2'h1 || I_MODE == 2'h3) ? 8'hff : 8'h00;
  assign sel3 = I_ACC_EXTERNAL && O_STATE_BITS[O_AREA];
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  // Bus mode changes on the same edge as the width register; checked over two samples
  AST_BUS8: assert property ((O_WIDTH_BITS == 8'hff) [*2] |-> O_BUS8_MODE)
    else $error("bus8 mode missing");
  AST_BUS16: assert property ((O_WIDTH_BITS != 8'hff) [*2] |-> !O_BUS8_MODE)
    else $error("bus16 mode missing");
  AST_PINS: assert property (O_PORT4_GPIO == O_BUS8_MODE && O_LOW_BYTE_EN != O_BUS8_MODE)
    else $error("port use wrong");
  // Address mode is latched at the first edge, so skip that edge
  AST_AREA: assert property ($past(I_RESETN) && I_ACC_EXTERNAL |->
    O_AREA == (mb1 ? I_ACC_ADDR[19:17] : I_ACC_ADDR[23:21]))
    else $error("area index wrong");
  AST_WIDTH: assert property (O_EIGHT_BIT == (I_ACC_EXTERNAL && O_WIDTH_BITS[O_AREA]))
    else $error("width wrong");
  AST_STATES: assert property (O_STATES == (sel3 ? 2'h3 : 2'h2))
    else $error("states wrong");
  AST_WAIT: assert property (O_WAIT_STRETCH == (I_WAIT_REQ && sel3))
    else $error("wait gate wrong");
  AST_HWSTBY: assert property (I_HW_STANDBY |=> O_WIDTH_BITS == wdef && O_STATE_BITS == 8'hff)
    else $error("standby init wrong");
  AST_SWSTBY: assert property (I_SW_STANDBY && !I_HW_STANDBY && O_AWREADY && O_WREADY
    |=> $stable(O_WIDTH_BITS) && $stable(O_STATE_BITS))
    else $error("sw standby changed regs");
  AST_RHOLD: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data not held");
  // Main scenarios
  cover property ($fell(O_BUS8_MODE));
  cover property (O_WAIT_STRETCH);
  cover property (I_HW_STANDBY ##1 !I_HW_STANDBY);
endmodule
bind abw_config_regs abw_checker #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// File: dv/abw_ext_mem.sv
// Model of the external memories and peripherals on the area bus
`timescale 1ns/1ns
`default_nettype none
module abw_ext_mem (
  // Clock and bench control
  input wire logic i_clk,
  input wire logic i_run,
  input wire logic i_rogue,
  // States of the current cycle
  input wire logic [1:0] i_states,
  // Bus cycle towards the controller
  output logic [23:0] o_addr,
  output logic o_external,
  output logic o_wait
);
  integer seed = 32'hec13;
  integer r;
  logic ph = 1'b0;
  // Quiet bus at time zero
  initial
    {o_addr, o_external, o_wait} = 26'h0;
  // Address moves on one edge, wait on the next, so wait sees settled states
  always @(posedge i_clk)
  begin
    r = $random(seed);
    if (i_run)
    begin
      ph <= !ph;
      if (!ph)
        {o_addr, o_external, o_wait} <= {r[24:0], 1'b0};
      else
        o_wait <= r[25] && (i_rogue || i_states == 2'h3);
    end
  end
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the area width and state configuration block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic ck = 1'b0;
  logic rn = 1'b0;
  logic hws = 1'b0;
  logic sws = 1'b0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bry = 1'b0;
  logic arv = 1'b0;
  logic rry = 1'b0;
  logic run = 1'b0;
  logic rog = 1'b0;
  logic [1:0] mode = 2'h1;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic awr, wr, bv, arr, rv, ax, wq, e8, ws, b8, lbe, p4;
  logic [1:0] br, rr, st, gr;
  logic [2:0] ar, ea;
  logic [7:0] wb, sb;
  logic [23:0] aa;
  logic [31:0] rd, got, d;
  integer num_errors = 0;
  integer num_checks = 0;
  integer seed = 32'hec13;
  integer cyc = 0;
  integer mw, ms, m, j;
  abw_config_regs i_dut (.I_CLK(ck), .I_RESETN(rn), .I_MODE(mode), .I_HW_STANDBY(hws),
    .I_SW_STANDBY(sws), .I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wd),
    .I_WSTRB(4'hf), .I_WVALID(wv), .O_WREADY(wr), .O_BRESP(br), .O_BVALID(bv),
    .I_BREADY(bry), .I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rd),
    .O_RRESP(rr), .O_RVALID(rv), .I_RREADY(rry), .I_ACC_ADDR(aa), .I_ACC_EXTERNAL(ax),
    .I_WAIT_REQ(wq), .O_AREA(ar), .O_EIGHT_BIT(e8), .O_STATES(st), .O_WAIT_STRETCH(ws),
    .O_BUS8_MODE(b8), .O_LOW_BYTE_EN(lbe), .O_PORT4_GPIO(p4), .O_WIDTH_BITS(wb),
    .O_STATE_BITS(sb));
  abw_ext_mem u_mem (.i_clk(ck), .i_run(run), .i_rogue(rog), .i_states(st), .o_addr(aa),
    .o_external(ax), .o_wait(wq));
  // 100 MHz clock
  initial
    forever #5 ck = !ck;
  task automatic print_verdict();
    if (num_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp_reg(input logic [33:0] g, input logic [33:0] e);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t reg got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_attr(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t attr got %h exp %h", $time, g, e);
    end
  endtask
  // Write: address and data offered together, each released once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    logic ta;
    logic tw;
    @(posedge ck);
    {awa, wd, awv, wv, bry} <= {a, v, 3'h7};
    while (awv || wv)
    begin
      @(negedge ck);
      ta = awv && awr;
      tw = wv && wr;
      @(posedge ck);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    while (bv !== 1'b1) @(negedge ck);
    @(posedge ck);
    bry <= 1'b0;
  endtask
  // Read: ready raised late so the held answer is exercised
  task automatic axr(input logic [7:0] a);
    @(posedge ck);
    {ara, arv} <= {a, 1'b1};
    @(negedge ck);
    while (arr !== 1'b1) @(negedge ck);
    @(posedge ck);
    arv <= 1'b0;
    @(negedge ck);
    while (rv !== 1'b1) @(negedge ck);
    @(posedge ck);
    rry <= 1'b1;
    @(negedge ck);
    {gr, got} = {rr, rd};
    @(posedge ck);
    rry <= 1'b0;
  endtask
  task automatic chk_regs();
    axr(abw_pkg::ADDR_WIDTH_SEL);
    cmp_reg({gr, got}, {abw_pkg::RESP_OKAY, 24'h0, mw[7:0]});
    axr(abw_pkg::ADDR_STATE_SEL);
    cmp_reg({gr, got}, {abw_pkg::RESP_OKAY, 24'h0, ms[7:0]});
    @(negedge ck);
    cmp_attr({b8, lbe, p4, 5'h0}, {mw[7:0] == 8'hff, mw[7:0] != 8'hff, mw[7:0] == 8'hff, 5'h0});
  endtask
  // Cycle ceiling cuts a hang short
  always @(posedge ck)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors = num_errors + 1;
      print_verdict();
    end
  end
  // Each mode: reset, defaults, writes, standby, bus cycles
  initial
  begin
    for (m = 0; m < 4; m++)
    begin
      {rn, mode} <= {1'b0, m[1:0]};
      repeat (12) @(posedge ck);
      rn <= 1'b1;
      mw = (m == 1 || m == 3) ? 8'hff : 8'h00;
      ms = 8'hff;
      repeat (3) @(posedge ck);
      chk_regs();
      axr(8'h10);
      cmp_reg({gr, got}, {abw_pkg::RESP_SLVERR, 32'h0});
      for (j = 0; j < 4; j++)
      begin
        d = (j == 3) ? 32'hff : $random(seed);
        axw(abw_pkg::ADDR_WIDTH_SEL, d);
        axw(abw_pkg::ADDR_STATE_SEL, {d[7:0], d[31:8]});
        {mw, ms} = {24'h0, d[7:0], 24'h0, d[15:8]};
        chk_regs();
      end
      sws <= 1'b1;
      repeat (20) @(posedge ck);
      chk_regs();
      {sws, run, rog} <= {2'h1, m[0]};
      repeat (200)
      begin
        @(negedge ck);
        ea = (m == 1 || m == 2) ? aa[19:17] : aa[23:21];
        cmp_attr({ax ? ar : 3'h0, e8, st, ws, 1'b0}, {ax ? ea : 3'h0, ax && mw[ea],
          (ax && ms[ea]) ? 2'h3 : 2'h2, wq && ax && ms[ea], 1'b0});
      end
      {run, hws} <= 2'h1;
      repeat (2) @(posedge ck);
      hws <= 1'b0;
      mw = (m == 1 || m == 3) ? 8'hff : 8'h00;
      ms = 8'hff;
      chk_regs();
    end
    print_verdict();
  end
endmodule
`default_nettype wire
